// ==== shared/epcm_cfg.svh ====
// Offsets, field positions, codes and timing counts of the condition manager
`ifndef EPCM_CFG_SVH
`define EPCM_CFG_SVH
// Register byte offsets
`define EPCM_OFF_CMD     8'h00
`define EPCM_OFF_ARG     8'h04
`define EPCM_OFF_STATUS  8'h08
`define EPCM_OFF_CTRL    8'h0C
// Command word fields
`define EPCM_CMD_SUB     3:0
`define EPCM_CMD_ID      15:8
`define EPCM_CMD_SAVE    16
`define EPCM_CMD_OPT     17
// Subcommands
`define EPCM_SUB_RESTORE 4'h0
`define EPCM_SUB_GOTO    4'h1
`define EPCM_SUB_TIMER   4'h2
`define EPCM_SUB_STATE   4'h3
`define EPCM_SUB_ENABLE  4'h4
`define EPCM_SUB_DISABLE 4'h5
// Condition identifiers
`define EPCM_ID_STBY_Z   8'h00
`define EPCM_ID_STBY_Y   8'h01
`define EPCM_ID_IDLE_B   8'h82
`define EPCM_ID_IDLE_C   8'h83
// Power-mode query answers
`define EPCM_PM_IDLE     8'hFF
`define EPCM_PM_STBY     8'h00
// Timing: one timer unit is 100 ms
`define EPCM_CLK_NS      20
`define EPCM_TICK_NS     100000000
`define EPCM_TICK_CYC    (`EPCM_TICK_NS / `EPCM_CLK_NS)
`define EPCM_TMR_W       16
// Reset values
`define EPCM_DEF_T_IB    16'h0001
`define EPCM_DEF_T_IC    16'h0002
`define EPCM_DEF_T_SY    16'h0003
`define EPCM_DEF_T_SZ    16'h0004
`endif

// ==== shared/epcm_pkg.sv ====
// Types of the condition manager
package epcm_pkg;
    // Ordered from highest power to lowest power
    typedef enum logic [1:0] {
        EPCM_IDLE_B,
        EPCM_IDLE_C,
        EPCM_STBY_Y,
        EPCM_STBY_Z
    } epcm_cond_e;
    typedef logic [7:0] epcm_id_t;
endpackage

// ==== rtl/epcm_top.sv ====
// Extended power condition manager with an Avalon-MM register slave
//
// Summary of operation
// - Abort feature subcommand when feature unsupported
// - Decode subcommands 0h-5h, abort reserved codes
// - Condition ids 00h,01h,82h,83h; others refused
// - Rank idle_b, idle_c, standby_y, standby_z
// - Keep current, saved and default timer settings
// - Zero timer value disables its condition
// - Power-on: feature enabled, default timers loaded
// - Report support and enabled timers identify bits
// - Enabled timers count concurrently since completion
// - Expiry only moves to lower power
// - Several eligible: enter lowest power one
// - Power cycle: saved to current, restart timers
// - Resets keep condition, restart timers
// - Never feature and APM active together
// - Disabled: abort all but enable subcommand
// - Power-mode query answers as unsupported device
// - Background activity freezes timers, then resume
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`include "epcm_cfg.svh"
module epcm_top #(
    parameter int                TW        = `EPCM_TMR_W,
    parameter int                TICK_CYC  = `EPCM_TICK_CYC,
    parameter bit                SUPPORTED = 1'b1,
    parameter logic [TW-1:0]     DEF_T_IB  = `EPCM_DEF_T_IB,
    parameter logic [TW-1:0]     DEF_T_IC  = `EPCM_DEF_T_IC,
    parameter logic [TW-1:0]     DEF_T_SY  = `EPCM_DEF_T_SY,
    parameter logic [TW-1:0]     DEF_T_SZ  = `EPCM_DEF_T_SZ
) (
    // Clock, reset, enable
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    // Avalon-MM slave
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    // Events from the drive controller
    input  wire logic            cmd_done,
    input  wire logic            bg_active,
    input  wire logic            dev_reset,
    input  wire logic            pwr_cycle,
    // Power state
    output epcm_pkg::epcm_cond_e cond,
    output logic                 standby_power_state,
    output logic                 epc_active,
    output logic                 apm_active,
    output logic                 id_supported,
    output logic                 id_timers_on
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Condition identifier to {valid, index}
    function automatic logic [2:0] id_decode(input epcm_pkg::epcm_id_t id);
        logic [2:0] r;
        r = 3'h0;
        if (id == `EPCM_ID_IDLE_B) r = 3'h4;
        if (id == `EPCM_ID_IDLE_C) r = 3'h5;
        if (id == `EPCM_ID_STBY_Y) r = 3'h6;
        if (id == `EPCM_ID_STBY_Z) r = 3'h7;
        return r;
    endfunction

    // State
    logic                 wait_q;
    logic [31:0]          rdata_q;
    logic [31:0]          cmd_q;
    logic [31:0]          arg_q;
    logic                 abort_q;
    logic                 epc_q;
    logic                 apm_q;
    logic                 id120_q;
    epcm_pkg::epcm_cond_e cond_q;
    logic [TW-1:0]        cur_q [4];
    logic [TW-1:0]        sav_q [4];
    logic [TW-1:0]        cnt_q [4];
    logic [3:0]           en_q;
    logic [PW-1:0]        pre_q;

    // Bus decode
    wire        req     = avs_read | avs_write;
    wire        acc     = req & ~wait_q;
    wire        wr_acc  = acc & avs_write;
    wire        hit_cmd = avs_address == `EPCM_OFF_CMD;
    wire        hit_arg = avs_address == `EPCM_OFF_ARG;
    wire        hit_st  = avs_address == `EPCM_OFF_STATUS;
    wire        hit_ctl = avs_address == `EPCM_OFF_CTRL;
    wire        wr_cmd  = wr_acc & hit_cmd & avs_byteenable[0];
    wire        wr_ctl  = wr_acc & hit_ctl & avs_byteenable[0];
    wire [31:0] cmd_w   = be_merge(cmd_q, avs_writedata, avs_byteenable);
    wire [31:0] arg_w   = be_merge(arg_q, avs_writedata, avs_byteenable);
    wire [31:0] ctl_w   = be_merge({31'h0, apm_q}, avs_writedata,
                                   avs_byteenable);

    // Subcommand fields
    wire [3:0]  sub     = cmd_w[`EPCM_CMD_SUB];
    wire [2:0]  idd     = id_decode(cmd_w[`EPCM_CMD_ID]);
    wire        id_ok   = idd[2];
    wire [1:0]  idx     = idd[1:0];
    wire        c_save  = cmd_w[`EPCM_CMD_SAVE];
    wire        c_opt   = cmd_w[`EPCM_CMD_OPT];
    wire        need_id = sub <= `EPCM_SUB_STATE;
    wire        ab_sup  = ~SUPPORTED;
    wire        ab_rsv  = sub > `EPCM_SUB_DISABLE;
    wire        ab_dis  = ~epc_q & (sub != `EPCM_SUB_ENABLE);
    wire        ab_id   = need_id & ~id_ok;
    wire        abort   = ab_sup | ab_rsv | ab_dis | ab_id;
    wire        cmd_ok  = wr_cmd & ~abort;
    wire        do_rst  = cmd_ok & (sub == `EPCM_SUB_RESTORE);
    wire        do_goto = cmd_ok & (sub == `EPCM_SUB_GOTO);
    wire        do_tmr  = cmd_ok & (sub == `EPCM_SUB_TIMER);
    wire        do_st   = cmd_ok & (sub == `EPCM_SUB_STATE);
    wire        do_en   = cmd_ok & (sub == `EPCM_SUB_ENABLE);
    wire        do_dis  = cmd_ok & (sub == `EPCM_SUB_DISABLE);

    // Defaults as a table; never written, so never modified
    logic [TW-1:0] def_t [4];
    assign def_t[0] = DEF_T_IB;
    assign def_t[1] = DEF_T_IC;
    assign def_t[2] = DEF_T_SY;
    assign def_t[3] = DEF_T_SZ;

    // Event handling; power cycle and resets act only when enabled
    wire pc_on   = pwr_cycle & epc_q;
    wire rst_on  = dev_reset & epc_q;
    wire restart = cmd_done | cmd_ok | pc_on | rst_on;
    wire run     = epc_q & ~bg_active;
    wire tick    = run & (pre_q == PRE_LAST);

    // Expiry and deepest eligible condition
    logic [3:0] expired;
    logic [3:0] enabled;
    logic [1:0] deep_idx;
    logic       any_exp;
    always_comb begin
        deep_idx = 2'h0;
        any_exp  = 1'b0;
        for (int i = 0; i < 4; i++) begin
            enabled[i] = en_q[i] & (cur_q[i] != '0);
            expired[i] = epc_q & enabled[i] & (cnt_q[i] == cur_q[i]);
            if (expired[i]) begin
                deep_idx = 2'(i);
                any_exp  = 1'b1;
            end
        end
    end
    // rank by enum order; only downward
    wire go_deep = any_exp & (deep_idx > cond_q);
    wire any_en  = epc_q & (|enabled);

    // Status word and read selection
    wire        stby   = cond_q >= epcm_pkg::EPCM_STBY_Y;
    // answer as a device without the feature
    wire [7:0]  pm     = stby ? `EPCM_PM_STBY : `EPCM_PM_IDLE;
    wire [31:0] st_w   = {16'h0000, pm, id120_q, SUPPORTED, abort_q,
                          apm_q, epc_q, stby, cond_q};
    wire [31:0] rd_mux = hit_cmd ? cmd_q :
                         hit_arg ? arg_q :
                         hit_st  ? st_w  :
                         hit_ctl ? {31'h0, apm_q} : 32'h0000_0000;

    // Bus handshake: one wait cycle, then one ready cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Argument and command registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q   <= 32'h0000_0000;
            arg_q   <= 32'h0000_0000;
            abort_q <= 1'b0;
        end else if (ce) begin
            if (wr_acc & hit_arg) arg_q <= arg_w;
            if (wr_cmd) begin
                cmd_q   <= cmd_w;
                abort_q <= abort;
            end
        end
    end

    // Feature and APM enables
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            epc_q <= SUPPORTED;
            apm_q <= 1'b0;
        end else if (ce) begin
            if (do_en) begin
                epc_q <= 1'b1;
                apm_q <= 1'b0;
            end else if (do_dis) begin
                epc_q <= 1'b0;
            end else if (wr_ctl) begin
                apm_q <= ctl_w[0];
                if (ctl_w[0]) epc_q <= 1'b0;
            end
        end
    end

    // Current, saved and enable settings per condition
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q[0] <= DEF_T_IB;
            cur_q[1] <= DEF_T_IC;
            cur_q[2] <= DEF_T_SY;
            cur_q[3] <= DEF_T_SZ;
            sav_q[0] <= DEF_T_IB;
            sav_q[1] <= DEF_T_IC;
            sav_q[2] <= DEF_T_SY;
            sav_q[3] <= DEF_T_SZ;
            en_q     <= 4'hF;
        end else if (ce) begin
            if (pc_on) begin
                for (int i = 0; i < 4; i++) cur_q[i] <= sav_q[i];
            end else if (do_rst) begin
                cur_q[idx] <= c_opt ? def_t[idx] : sav_q[idx];
                en_q[idx]  <= 1'b1;
                if (c_save & c_opt) sav_q[idx] <= def_t[idx];
            end else if (do_tmr) begin
                cur_q[idx] <= arg_q[TW-1:0];
                if (c_save) sav_q[idx] <= arg_q[TW-1:0];
            end else if (do_st) begin
                en_q[idx] <= c_opt;
            end
        end
    end

    // concurrent timers with a shared prescaler
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            for (int i = 0; i < 4; i++) cnt_q[i] <= '0;
        end else if (ce) begin
            if (restart | ~epc_q) pre_q <= '0;
            else if (tick) pre_q <= '0;
            else if (run) pre_q <= pre_q + 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (restart | ~epc_q) cnt_q[i] <= '0;
                else if (tick & (cnt_q[i] != cur_q[i]))
                    cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

    // Present condition; power cycle spins back to active idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_q <= epcm_pkg::EPCM_IDLE_B;
        end else if (ce) begin
            if (pc_on) cond_q <= epcm_pkg::EPCM_IDLE_B;
            else if (rst_on) cond_q <= cond_q;
            else if (do_goto) cond_q <= epcm_pkg::epcm_cond_e'(idx);
            else if (go_deep) cond_q <= epcm_pkg::epcm_cond_e'(deep_idx);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) id120_q <= 1'b0;
        else if (ce) id120_q <= any_en;
    end

    // Outputs straight from flops, id_supported from the SUPPORTED parameter
    assign avs_readdata        = rdata_q;
    assign avs_waitrequest     = wait_q;
    assign cond                = cond_q;
    assign standby_power_state = cond_q[1];
    assign epc_active          = epc_q;
    assign apm_active          = apm_q;
    assign id_supported        = SUPPORTED;
    assign id_timers_on        = id120_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_WAIT_ONE: assert property (
        ce && req && wait_q |=> !wait_q ##1 wait_q)
        else $error("waitrequest not low for exactly one cycle");
    AST_RESERVED: assert property (
        ce && wr_cmd && sub > 4'h5 && !go_deep && !pc_on
        |=> abort_q && $stable(cond_q))
        else $error("reserved subcommand not aborted");
    AST_DISABLED: assert property (
        ce && wr_cmd && !epc_q && sub != 4'h4 |=> abort_q && !epc_q)
        else $error("subcommand accepted while feature disabled");
    AST_BAD_ID: assert property (
        ce && wr_cmd && sub == 4'h1 && cmd_w[15:8] == 8'h81 && !go_deep
        && !pc_on |=> abort_q && $stable(cond_q))
        else $error("unsupported condition id accepted");
    AST_MUTEX: assert property (
        !(epc_q && apm_q))
        else $error("feature and APM active together");
    AST_FREEZE: assert property (
        ce && epc_q && bg_active && !restart
        |=> $stable(pre_q) && $stable(cnt_q[3]))
        else $error("timer moved during background activity");
    AST_NO_RISE: assert property (
        !(ce && (wr_cmd || pc_on)) |=> cond_q >= $past(cond_q))
        else $error("timer expiry raised the power condition");
    AST_DEEPEST: assert property (
        ce && go_deep && !pc_on && !rst_on && !do_goto
        |=> cond_q == $past(deep_idx))
        else $error("did not enter lowest power eligible condition");
    AST_RST_KEEP: assert property (
        ce && rst_on && !pc_on |=> $stable(cond_q) && cnt_q[0] == '0)
        else $error("reset changed condition or left timers running");
    AST_DONE_RESTART: assert property (
        ce && cmd_done |=> cnt_q[1] == '0 && pre_q == '0)
        else $error("completion did not restart timers");
    AST_ID120: assert property (
        ce && epc_q && en_q == 4'hF && cur_q[2] != '0 |=> id120_q)
        else $error("enabled timers bit not reported");
endmodule

// ==== sim/epcm_host_model.sv ====
// Host-side model: one Avalon-MM transfer per bench request
module epcm_host_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Bench request side
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    // Avalon-MM master
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;

    // Avalon-MM read or write issue
    // Request held until waitrequest low; data scrambled once released
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_read       <= 1'h0;
            avs_write      <= 1'h0;
            avs_address    <= 8'h00;
            avs_writedata  <= 32'h0;
            avs_byteenable <= 4'hF;
            rdata          <= 32'h0;
            done           <= 1'h0;
        end else begin
            done <= 1'h0;
            if (avs_read || avs_write) begin
                if (!avs_waitrequest) begin
                    avs_read      <= 1'h0;
                    avs_write     <= 1'h0;
                    avs_writedata <= ~avs_writedata;
                    rdata         <= avs_readdata;
                    done          <= 1'h1;
                end
            end else if (go) begin
                avs_read      <= !wr;
                avs_write     <= wr;
                avs_address   <= addr;
                avs_writedata <= wdata;
            end
        end
    end
endmodule

// ==== sim/extended_power_condition_manager_tb_top.sv ====
// Self-checking bench of the condition manager
`include "epcm_cfg.svh"
module extended_power_condition_manager_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    logic sys_clk = 0, rst_n = 0, ce = 1, go = 0, wr = 0, done;
    logic cmd_done = 0, bg_active = 0, dev_reset = 0, pwr_cycle = 0;
    logic [7:0] addr = 8'h00, a_addr;
    logic [31:0] wdata = 32'h0, rdata, a_wd, a_rd, rv;
    logic [3:0] a_be;
    logic a_rdq, a_wrq, a_wait, stby, epc, apm, sup, tmr;
    epcm_pkg::epcm_cond_e cond;
    logic [16:0] s = 17'h1166D;
    int fail_count = 0, checks = 0, n;
    // Half-period toggle of the 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    epcm_top #(.TICK_CYC(TK)) i_epcm_top (.sys_clk(sys_clk),
        .rst_n(rst_n), .ce(ce), .avs_address(a_addr), .avs_read(a_rdq),
        .avs_write(a_wrq), .avs_writedata(a_wd), .avs_byteenable(a_be),
        .avs_readdata(a_rd), .avs_waitrequest(a_wait),
        .cmd_done(cmd_done), .bg_active(bg_active), .dev_reset(dev_reset),
        .pwr_cycle(pwr_cycle), .cond(cond), .standby_power_state(stby),
        .epc_active(epc), .apm_active(apm), .id_supported(sup),
        .id_timers_on(tmr));
    epcm_host_model i_epcm_host_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .go(go), .wr(wr), .addr(addr), .wdata(wdata), .done(done),
        .rdata(rdata), .avs_address(a_addr), .avs_read(a_rdq),
        .avs_write(a_wrq), .avs_writedata(a_wd), .avs_byteenable(a_be),
        .avs_readdata(a_rd), .avs_waitrequest(a_wait));

    // Counts, verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Next random value, 17-bit maximal sequence
    function automatic logic [16:0] lfsr(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    function automatic logic vid(input logic [7:0] id);
        return id == 8'h00 || id == 8'h01 || id == 8'h82 || id == 8'h83;
    endfunction
    // Abort expected from subcommand, identifier and feature state
    function automatic logic exp_abort(input logic [3:0] sb,
                                       input logic [7:0] id, input logic en);
        return (!en && sb != 4'h4) || sb > 4'h5 || (sb < 4'h4 && !vid(id));
    endfunction
    function automatic logic [1:0] cond_of(input logic [7:0] id);
        return id == 8'h82 ? 2'h0 : id == 8'h83 ? 2'h1 :
               id == 8'h01 ? 2'h2 : 2'h3;
    endfunction
    // One bus transfer through the host model, bounded wait
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        go <= 1'h1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        go <= 1'h0;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (done !== 1'h1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            end_sim();
        end
        rv = rdata;
    endtask
    task automatic cmd(input logic [3:0] sb, input logic [7:0] id,
                       input logic opt);
        bus(1'h1, `EPCM_OFF_CMD, {14'h0, opt, 1'h0, id, 4'h0, sb});
    endtask
    task automatic tmr_set(input logic [7:0] id, input logic [15:0] v);
        bus(1'h1, `EPCM_OFF_ARG, {16'h0, v});
        cmd(`EPCM_SUB_TIMER, id, 1'h0);
    endtask
    // Pulse one event input for a cycle
    task automatic ev(input int k);
        @(posedge sys_clk);
        case (k)
            0: cmd_done <= 1'h1;
            1: dev_reset <= 1'h1;
            default: pwr_cycle <= 1'h1;
        endcase
        @(posedge sys_clk);
        {cmd_done, dev_reset, pwr_cycle} <= 3'h0;
    endtask
    // Wait for a condition, never moving back to higher power
    task automatic wcond(input logic [1:0] c, input int lim);
        logic [1:0] p;
        p = cond;
        n = 0;
        while (cond !== c && n < lim) begin
            @(posedge sys_clk);
            #1;
            if (cond < p) ck(cond, p);
            p = cond;
            n++;
        end
        ck(cond, c);
    endtask
    task automatic hold(input logic [1:0] c, input int cyc);
        repeat (cyc) @(posedge sys_clk);
        #1;
        ck(cond, c);
    endtask

    // Watchdog: a hang ends the run as a mismatch
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [3:0] sb;
        logic [7:0] id;
        logic ab;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1;
        ck({cond, epc, apm, sup, tmr}, {2'h0, 4'hB});
        $display("test reset done");
        // Default timers walk down through every condition in rank order
        ev(0);
        wcond(2'h1, 2 * TK + 4);
        ck(stby, 1'h0);
        wcond(2'h2, TK + 4);
        wcond(2'h3, TK + 4);
        ck(stby, 1'h1);
        bus(1'h0, `EPCM_OFF_STATUS, 32'h0);
        ck(rv[15:8], `EPCM_PM_STBY);
        $display("test timers done");
        // Completions closer than the shortest step keep the condition
        cmd(`EPCM_SUB_GOTO, `EPCM_ID_IDLE_B, 1'h0);
        repeat (12) ev(0);
        #1;
        ck(cond, 2'h0);
        bg_active <= 1'h1;
        hold(2'h0, 40);
        bg_active <= 1'h0;
        // Clock enable low freezes timers and condition
        ce <= 1'h0;
        hold(2'h0, 40);
        ce <= 1'h1;
        wcond(2'h3, 4 * TK + 8);
        $display("test restart done");
        // Deepest timer shortest: goes straight there and stays
        tmr_set(`EPCM_ID_STBY_Z, 16'h0001);
        cmd(`EPCM_SUB_GOTO, `EPCM_ID_IDLE_B, 1'h0);
        wcond(2'h3, TK + 4);
        hold(2'h3, 4 * TK);
        // Zero timers disable conditions
        tmr_set(`EPCM_ID_STBY_Z, 16'h0000);
        tmr_set(`EPCM_ID_STBY_Y, 16'h0000);
        tmr_set(`EPCM_ID_IDLE_C, 16'h0000);
        cmd(`EPCM_SUB_GOTO, `EPCM_ID_IDLE_B, 1'h0);
        hold(2'h0, 6 * TK);
        ck(tmr, 1'h1);
        tmr_set(`EPCM_ID_IDLE_B, 16'h0000);
        hold(2'h0, 2);
        ck(tmr, 1'h0);
        // Power cycle brings saved defaults back
        ev(2);
        wcond(2'h3, 4 * TK + 8);
        ck(tmr, 1'h1);
        ev(1);
        hold(2'h3, 3 * TK);
        $display("test settings done");
        // Set state disables a condition, restore brings it back
        cmd(`EPCM_SUB_STATE, `EPCM_ID_STBY_Z, 1'h0);
        cmd(`EPCM_SUB_GOTO, `EPCM_ID_IDLE_B, 1'h0);
        wcond(2'h2, 4 * TK);
        hold(2'h2, 4 * TK);
        cmd(`EPCM_SUB_RESTORE, `EPCM_ID_STBY_Z, 1'h0);
        wcond(2'h3, 4 * TK + 8);
        // Saved timer survives a power cycle
        bus(1'h1, `EPCM_OFF_ARG, 32'h0000_0002);
        bus(1'h1, `EPCM_OFF_CMD, {15'h0, 1'h1, `EPCM_ID_STBY_Z, 4'h0,
                                  `EPCM_SUB_TIMER});
        ev(2);
        hold(2'h0, 1);
        wcond(2'h3, 2 * TK + 4);
        $display("test saved settings done");
        // Reserved subcommands and random identifiers
        for (int i = 0; i < 16; i++) begin
            s = lfsr(s);
            sb = (i < 10) ? 4'(i + 6) : `EPCM_SUB_GOTO;
            id = s[12] ? {s[13], 6'h0, s[14]} : s[7:0];
            if (id == 8'h80) id = 8'h83;
            ab = exp_abort(sb, id, 1'h1);
            cmd(sb, id, 1'h0);
            if (!ab) ck(cond, cond_of(id));
            bus(1'h0, `EPCM_OFF_STATUS, 32'h0);
            ck(rv[5], ab);
        end
        // Disabled feature aborts subcommands 0h-3h, then enable is accepted
        cmd(`EPCM_SUB_DISABLE, 8'h00, 1'h0);
        ck(epc, 1'h0);
        for (int i = 0; i < 4; i++) begin
            cmd(4'(i), 8'h82, 1'h0);
            bus(1'h0, `EPCM_OFF_STATUS, 32'h0);
            ck(rv[5], exp_abort(4'(i), 8'h82, 1'h0));
        end
        cmd(`EPCM_SUB_ENABLE, 8'h00, 1'h0);
        ck({epc, apm}, 2'h2);
        bus(1'h1, `EPCM_OFF_CTRL, 32'h1);
        ck({epc, apm}, 2'h1);
        cmd(`EPCM_SUB_ENABLE, 8'h00, 1'h0);
        ck({epc, apm}, 2'h2);
        bus(1'h0, 8'h10, 32'h0);
        ck(rv, 32'h0);
        $display("test commands done");
        end_sim();
    end
endmodule
